// *** rtl/acc_config_regs.sv ***
// conversion configuration register bank, registers one to three, with per-conversion settings latch
`timescale 1ns/10ps
module acc_config_regs #(
   parameter int EXT_CLK_HZ = 4096000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port from the serial command decoder
   input wire logic reg_strobe,
   input wire acc_pkg::acc_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // conversion control events
   input wire logic start_cmd,
   input wire logic sleep_cmd,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic data_ready_event,
   input wire logic data_read_done,
   // settings for the analogue section and filter
   output acc_pkg::acc_cfg_t active_cfg,
   output logic ignore_reg_zero,
   output logic internal_ref_forced,
   output logic [31:0] rate_csps,
   output logic rate_valid,
   output logic line_reject_misuse,
   output logic lowside_switch_closed,
   output logic [3:0] source_one_ain_en,
   output logic [3:0] source_two_ain_en,
   output logic [1:0] source_one_ref_en,
   output logic [1:0] source_two_ref_en,
   output logic [2:0] excitation_magnitude_sel,
   // ready pins
   output logic data_ready_n,
   output logic shared_out_ready_req
);
   import acc_pkg::*;

   logic [7:0] rate_mode_control_r;
   logic [7:0] reference_filter_current_control_r;
   logic [7:0] current_routing_ready_control_r;
   acc_cfg_t shadow_cfg;
   acc_cfg_t active_cfg_r;
   logic busy_r;
   logic switch_r;
   logic ready_r;
   logic wr_one, wr_two, wr_three;

   // address decode; register zero lives elsewhere so it is not a hit here
   assign wr_one = reg_strobe & reg_req.wr & (reg_req.addr == ACC_OFF_RATE_MODE);
   assign wr_two = reg_strobe & reg_req.wr & (reg_req.addr == ACC_OFF_REF_FILT);
   assign wr_three = reg_strobe & reg_req.wr & (reg_req.addr == ACC_OFF_ROUTE_RDY);
   assign reg_hit = reg_req.addr != 2'h0;

   // registers store at once, any time, and keep through sleep
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rate_mode_control_r <= ACC_RST_RATE_MODE;
         reference_filter_current_control_r <= ACC_RST_REF_FILT;
         current_routing_ready_control_r <= ACC_RST_ROUTE_RDY;
      end else begin
         if (wr_one) rate_mode_control_r <= reg_req.wdata;
         if (wr_two) reference_filter_current_control_r <= reg_req.wdata;
         if (wr_three) current_routing_ready_control_r <= reg_req.wdata;
      end
   end

   // read mux; unmapped address reads zero
   always_comb begin
      unique case (reg_req.addr)
         ACC_OFF_RATE_MODE: reg_rdata = rate_mode_control_r;
         ACC_OFF_REF_FILT: reg_rdata = reference_filter_current_control_r;
         ACC_OFF_ROUTE_RDY: reg_rdata = current_routing_ready_control_r;
         default: reg_rdata = 8'h00;
      endcase
   end

   // field split of the stored registers
   assign shadow_cfg.rate_code = rate_mode_control_r[ACC_POS_RATE +: 3];
   assign shadow_cfg.mode = acc_mode_t'(rate_mode_control_r[ACC_POS_MODE +: 2]);
   assign shadow_cfg.continuous_convert_sel = rate_mode_control_r[ACC_POS_CONT];
   assign shadow_cfg.temp_sensor_sel = rate_mode_control_r[ACC_POS_TEMP];
   assign shadow_cfg.burnout_source_en = rate_mode_control_r[ACC_POS_BURN];
   assign shadow_cfg.vref_sel = acc_ref_t'(reference_filter_current_control_r[ACC_POS_VREF +: 2]);
   assign shadow_cfg.line_reject = reference_filter_current_control_r[ACC_POS_LINE +: 2];
   assign shadow_cfg.lowside_switch_auto = reference_filter_current_control_r[ACC_POS_PSW];
   assign shadow_cfg.excitation_magnitude_sel = reference_filter_current_control_r[ACC_POS_MAG +: 3];
   assign shadow_cfg.source_one_route_sel = current_routing_ready_control_r[ACC_POS_ROUTE1 +: 3];
   assign shadow_cfg.source_two_route_sel = current_routing_ready_control_r[ACC_POS_ROUTE2 +: 3];
   assign shadow_cfg.ready_shared_pin_sel = current_routing_ready_control_r[ACC_POS_RDYM];

   // conversion tracking; a start in the same cycle as a done keeps busy
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= conv_start | (busy_r & ~conv_done);
      end
   end

   // settings latch at each conversion start, so mid-conversion writes wait
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         active_cfg_r <= '0;
      end else if (conv_start | ~busy_r) begin
         active_cfg_r <= shadow_cfg;
      end
   end
   assign active_cfg = active_cfg_r;

   // temperature mode overrides register zero and reference choice
   assign ignore_reg_zero = active_cfg_r.temp_sensor_sel;
   assign internal_ref_forced = active_cfg_r.temp_sensor_sel | (active_cfg_r.vref_sel == ACC_REF_INTERNAL);

   // flag for rejection outside the two slow rates; not blocked, only reported
   assign line_reject_misuse = (active_cfg_r.line_reject != 2'b00) & ~(active_cfg_r.rate_code == 3'h0 &
      (active_cfg_r.mode == ACC_MODE_NORMAL | active_cfg_r.mode == ACC_MODE_DUTY));

   // output rate from mode and code
   acc_rate_lut #(
      .EXT_CLK_HZ(EXT_CLK_HZ)
   ) u_rate (
      .mode(active_cfg_r.mode),
      .rate_code(active_cfg_r.rate_code),
      .rate_csps(rate_csps),
      .rate_valid(rate_valid)
   );

   // low-side switch: closes on start, opens on sleep; open whenever auto is off
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         switch_r <= 1'b0;
      end else if (!shadow_cfg.lowside_switch_auto || sleep_cmd) begin
         switch_r <= 1'b0;
      end else if (start_cmd) begin
         switch_r <= 1'b1;
      end
   end
   assign lowside_switch_closed = switch_r;

   // excitation magnitude, reserved code treated as off
   assign excitation_magnitude_sel = (active_cfg_r.excitation_magnitude_sel == ACC_MAG_RSVD) ? 3'h0 :
      active_cfg_r.excitation_magnitude_sel;

   // routing decode: codes 1..4 onto inputs, 5/6 onto ref pins, 7 left off
   assign source_one_ain_en = (active_cfg_r.source_one_route_sel inside {3'h1, 3'h2, 3'h3, 3'h4}) ?
      4'(4'h1 << (active_cfg_r.source_one_route_sel - 3'h1)) : 4'h0;
   assign source_two_ain_en = (active_cfg_r.source_two_route_sel inside {3'h1, 3'h2, 3'h3, 3'h4}) ?
      4'(4'h1 << (active_cfg_r.source_two_route_sel - 3'h1)) : 4'h0;
   assign source_one_ref_en = {active_cfg_r.source_one_route_sel == 3'h6,
      active_cfg_r.source_one_route_sel == 3'h5};
   assign source_two_ref_en = {active_cfg_r.source_two_route_sel == 3'h6,
      active_cfg_r.source_two_route_sel == 3'h5};

   // ready flag: new data sets, a finished read clears; set wins
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= data_ready_event | (ready_r & ~data_read_done);
      end
   end
   assign data_ready_n = ~ready_r;
   assign shared_out_ready_req = ready_r & current_routing_ready_control_r[ACC_POS_RDYM];

   // a write to register two shows up on the next read
   property p_write_two;
      @(posedge core_clk) disable iff (rst)
      wr_two |=> reference_filter_current_control_r == $past(reg_req.wdata);
   endproperty
   a_write_two: assert property (p_write_two) else $error("register two write lost");

   property p_hold_in_conv;
      @(posedge core_clk) disable iff (rst)
      (busy_r & ~conv_start) |=> $stable(active_cfg_r);
   endproperty
   a_hold_in_conv: assert property (p_hold_in_conv) else $error("settings changed mid conversion");

   property p_start_loads;
      @(posedge core_clk) disable iff (rst)
      conv_start |=> active_cfg_r == $past(shadow_cfg);
   endproperty
   a_start_loads: assert property (p_start_loads) else $error("settings not applied at start");

   property p_switch_open;
      @(posedge core_clk) disable iff (rst)
      (sleep_cmd | ~shadow_cfg.lowside_switch_auto) |=> ~lowside_switch_closed;
   endproperty
   a_switch_open: assert property (p_switch_open) else $error("switch not open");

   property p_switch_close;
      @(posedge core_clk) disable iff (rst)
      (start_cmd & ~sleep_cmd & shadow_cfg.lowside_switch_auto) |=> lowside_switch_closed;
   endproperty
   a_switch_close: assert property (p_switch_close) else $error("switch not closed on start");

   property p_temp_ref;
      @(posedge core_clk) disable iff (rst)
      (shadow_cfg.temp_sensor_sel & (conv_start | ~busy_r)) |=> internal_ref_forced & ignore_reg_zero;
   endproperty
   a_temp_ref: assert property (p_temp_ref) else $error("temp mode not forcing internal ref");

   property p_shared_ready;
      @(posedge core_clk) disable iff (rst)
      (data_ready_event & current_routing_ready_control_r[ACC_POS_RDYM] & ~wr_three) |=> shared_out_ready_req;
   endproperty
   a_shared_ready: assert property (p_shared_ready) else $error("shared ready not raised");

   property p_ready_set;
      @(posedge core_clk) disable iff (rst)
      data_ready_event |=> ~data_ready_n;
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("ready event lost");

   property p_route_onehot;
      @(posedge core_clk) disable iff (rst)
      $onehot0({source_one_ain_en, source_one_ref_en});
   endproperty
   a_route_onehot: assert property (p_route_onehot) else $error("source one routed twice");

   property p_rate_rsvd;
      @(posedge core_clk) disable iff (rst)
      (active_cfg_r.rate_code == ACC_RATE_RSVD) |-> ~rate_valid;
   endproperty
   a_rate_rsvd: assert property (p_rate_rsvd) else $error("reserved rate gave a rate");

   // register one and three writes land whole
   property p_write_one;
      @(posedge core_clk) disable iff (rst)
      wr_one |=> rate_mode_control_r == $past(reg_req.wdata);
   endproperty
   a_write_one: assert property (p_write_one) else $error("register one write lost");

   property p_write_three;
      @(posedge core_clk) disable iff (rst)
      wr_three |=> current_routing_ready_control_r == $past(reg_req.wdata);
   endproperty
   a_write_three: assert property (p_write_three) else $error("register three write lost");

   // no write, no change: sleep and conversions never disturb the bank
   property p_no_write_hold;
      @(posedge core_clk) disable iff (rst)
      ~(wr_one | wr_two | wr_three) |=> $stable(rate_mode_control_r) &&
         $stable(reference_filter_current_control_r) && $stable(current_routing_ready_control_r);
   endproperty
   a_no_write_hold: assert property (p_no_write_hold) else $error("register changed without write");

   property p_idle_follows;
      @(posedge core_clk) disable iff (rst)
      ~busy_r |=> active_cfg_r == $past(shadow_cfg);
   endproperty
   a_idle_follows: assert property (p_idle_follows) else $error("idle settings not following");

   property p_busy_track;
      @(posedge core_clk) disable iff (rst)
      conv_start |=> busy_r;
   endproperty
   a_busy_track: assert property (p_busy_track) else $error("conversion start not tracked");

   property p_ready_clear;
      @(posedge core_clk) disable iff (rst)
      (data_read_done & ~data_ready_event) |=> data_ready_n;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared by read");

   // switch keeps its state between commands while auto is on
   property p_switch_hold;
      @(posedge core_clk) disable iff (rst)
      (~start_cmd & ~sleep_cmd & shadow_cfg.lowside_switch_auto) |=> $stable(lowside_switch_closed);
   endproperty
   a_switch_hold: assert property (p_switch_hold) else $error("switch moved without command");

   property p_mode_rsvd;
      @(posedge core_clk) disable iff (rst)
      (active_cfg_r.mode == ACC_MODE_RSVD) |-> ~rate_valid;
   endproperty
   a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode gave a rate");

   property p_route_two_onehot;
      @(posedge core_clk) disable iff (rst)
      $onehot0({source_two_ain_en, source_two_ref_en});
   endproperty
   a_route_two_onehot: assert property (p_route_two_onehot) else $error("source two routed twice");

   property p_route_rsvd;
      @(posedge core_clk) disable iff (rst)
      (active_cfg_r.source_one_route_sel == ACC_ROUTE_RSVD) |-> ({source_one_ain_en, source_one_ref_en} == 6'h0);
   endproperty
   a_route_rsvd: assert property (p_route_rsvd) else $error("reserved route drives a pin");

   property p_mag_rsvd;
      @(posedge core_clk) disable iff (rst)
      (active_cfg_r.excitation_magnitude_sel == ACC_MAG_RSVD) |-> (excitation_magnitude_sel == 3'h0);
   endproperty
   a_mag_rsvd: assert property (p_mag_rsvd) else $error("reserved magnitude not off");

   // misuse is reported for any rejection at a rate code above the slowest
   property p_misuse;
      @(posedge core_clk) disable iff (rst)
      ((active_cfg_r.line_reject != 2'b00) & (active_cfg_r.rate_code != 3'h0)) |-> line_reject_misuse;
   endproperty
   a_misuse: assert property (p_misuse) else $error("rejection misuse not flagged");
endmodule

// *** rtl/acc_pkg.sv ***
// package of offsets, field layouts, reset values and decoded setting types for the conversion config bank
package acc_pkg;
   // register addresses on the internal register port
   localparam logic [1:0] ACC_OFF_RATE_MODE = 2'h1;
   localparam logic [1:0] ACC_OFF_REF_FILT = 2'h2;
   localparam logic [1:0] ACC_OFF_ROUTE_RDY = 2'h3;
   // reset values
   localparam logic [7:0] ACC_RST_RATE_MODE = 8'h00;
   localparam logic [7:0] ACC_RST_REF_FILT = 8'h00;
   localparam logic [7:0] ACC_RST_ROUTE_RDY = 8'h00;
   // field positions, register one
   localparam int ACC_POS_RATE = 5;
   localparam int ACC_POS_MODE = 3;
   localparam int ACC_POS_CONT = 2;
   localparam int ACC_POS_TEMP = 1;
   localparam int ACC_POS_BURN = 0;
   // field positions, register two
   localparam int ACC_POS_VREF = 6;
   localparam int ACC_POS_LINE = 4;
   localparam int ACC_POS_PSW = 3;
   localparam int ACC_POS_MAG = 0;
   // field positions, register three
   localparam int ACC_POS_ROUTE1 = 5;
   localparam int ACC_POS_ROUTE2 = 2;
   localparam int ACC_POS_RDYM = 1;
   localparam int ACC_POS_RSVD = 0;
   // nominal clock for the listed rates, in hertz
   localparam int ACC_NOM_CLK_HZ = 4096000;
   // reserved codes
   localparam logic [2:0] ACC_RATE_RSVD = 3'h7;
   localparam logic [2:0] ACC_MAG_RSVD = 3'h1;
   localparam logic [2:0] ACC_ROUTE_RSVD = 3'h7;

   typedef enum logic [1:0] {
      ACC_MODE_NORMAL = 2'b00,
      ACC_MODE_DUTY = 2'b01,
      ACC_MODE_TURBO = 2'b10,
      ACC_MODE_RSVD = 2'b11
   } acc_mode_t;

   typedef enum logic [1:0] {
      ACC_REF_INTERNAL = 2'b00,
      ACC_REF_DEDICATED = 2'b01,
      ACC_REF_SHARED_AIN = 2'b10,
      ACC_REF_SUPPLY = 2'b11
   } acc_ref_t;

   // register access request from the serial command decoder
   typedef struct packed {
      logic wr;
      logic [1:0] addr;
      logic [7:0] wdata;
   } acc_req_t;

   // settings applied to the converter for the running conversion
   typedef struct packed {
      logic [2:0] rate_code;
      acc_mode_t mode;
      logic continuous_convert_sel;
      logic temp_sensor_sel;
      logic burnout_source_en;
      acc_ref_t vref_sel;
      logic [1:0] line_reject;
      logic lowside_switch_auto;
      logic [2:0] excitation_magnitude_sel;
      logic [2:0] source_one_route_sel;
      logic [2:0] source_two_route_sel;
      logic ready_shared_pin_sel;
   } acc_cfg_t;
endpackage

// *** rtl/acc_rate_lut.sv ***
// rate lookup: output rate in centi-samples per second for a mode and rate code, scaled by clock
`timescale 1ns/10ps
module acc_rate_lut #(
   parameter int EXT_CLK_HZ = 4096000
) (
   // setting in
   input wire acc_pkg::acc_mode_t mode,
   input wire logic [2:0] rate_code,
   // rate out
   output logic [31:0] rate_csps,
   output logic rate_valid
);
   import acc_pkg::*;

   logic [31:0] base_csps;
   logic [63:0] scaled;

   // nominal table in hundredths so duty-cycle fractional rates stay exact
   always_comb begin
      base_csps = 32'h0;
      unique case (mode)
         ACC_MODE_NORMAL: begin
            case (rate_code)
               3'h0: base_csps = 32'd2000;
               3'h1: base_csps = 32'd4500;
               3'h2: base_csps = 32'd9000;
               3'h3: base_csps = 32'd17500;
               3'h4: base_csps = 32'd33000;
               3'h5: base_csps = 32'd60000;
               3'h6: base_csps = 32'd100000;
               default: base_csps = 32'h0;
            endcase
         end
         ACC_MODE_DUTY: begin
            case (rate_code)
               3'h0: base_csps = 32'd500;
               3'h1: base_csps = 32'd1125;
               3'h2: base_csps = 32'd2250;
               3'h3: base_csps = 32'd4400;
               3'h4: base_csps = 32'd8250;
               3'h5: base_csps = 32'd15000;
               3'h6: base_csps = 32'd25000;
               default: base_csps = 32'h0;
            endcase
         end
         ACC_MODE_TURBO: begin
            case (rate_code)
               3'h0: base_csps = 32'd4000;
               3'h1: base_csps = 32'd9000;
               3'h2: base_csps = 32'd18000;
               3'h3: base_csps = 32'd35000;
               3'h4: base_csps = 32'd66000;
               3'h5: base_csps = 32'd120000;
               3'h6: base_csps = 32'd200000;
               default: base_csps = 32'h0;
            endcase
         end
         ACC_MODE_RSVD: base_csps = 32'h0;
      endcase
   end

   // proportional scaling with the converter clock
   assign scaled = 64'(base_csps) * 64'(EXT_CLK_HZ) / 64'(ACC_NOM_CLK_HZ);
   assign rate_csps = scaled[31:0];
   assign rate_valid = (base_csps != 32'h0);
endmodule

// *** tb/acc_host_model.sv ***
// host-side model of the serial command decoder feeding the register port
`timescale 1ns/10ps
module acc_host_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // command from the bench
   input wire logic go,
   input wire logic wr,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic bad,
   // register port
   output logic reg_strobe,
   output acc_pkg::acc_req_t reg_req
);
   import acc_pkg::*;
   logic [7:0] shadow_r;
   logic [7:0] sent;
   logic filt_ok;

   // own copy of rate and mode, so rejection is only asked for where it is legal
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shadow_r <= 8'h00;
      end else if (reg_strobe && reg_req.wr && reg_req.addr == ACC_OFF_RATE_MODE) begin
         shadow_r <= reg_req.wdata;
      end
   end

   // a well-behaved host scrubs what it may not write; bad lets the bench break that on purpose
   assign filt_ok = shadow_r[7:5] == 3'h0 && !shadow_r[4];
   always_comb begin
      sent = wdata;
      if (!bad && addr == ACC_OFF_REF_FILT && !filt_ok) sent[5:4] = 2'h0;
      if (!bad && addr == ACC_OFF_ROUTE_RDY) sent[0] = 1'b0;
   end

   // only read and write commands reach the bank; idle data is scrambled, not held
   assign reg_strobe = go;
   assign reg_req = '{wr: wr, addr: addr, wdata: (go && wr) ? sent : ~sent};
endmodule

// *** tb/adc_conversion_config_regs_tb.sv ***
// self-checking bench for the conversion configuration bank
`timescale 1ns/10ps
module adc_conversion_config_regs_tb;
   import acc_pkg::*;
   localparam int EXT_HZ = 8192000;
   logic core_clk = 0, rst = 1, go = 0, wr = 0, bad = 0;
   logic [1:0] addr = 0;
   logic [7:0] wdata = 0, rdata;
   logic [5:0] ev = 0;
   logic reg_strobe, hit, rv, misuse, sw, rdy_n, shr, ign, iref;
   acc_req_t reg_req;
   acc_cfg_t cfg;
   logic [31:0] rate;
   logic [3:0] a1, a2;
   logic [1:0] r1, r2;
   logic [2:0] mag, ctb, em;
   logic [7:0] exp_r [4];
   int seed = 2, miscompares = 0, n_checks = 0;

   always #20 core_clk = ~core_clk;

   // conversion, temp and burn-out bits of the applied settings
   assign ctb = {cfg.continuous_convert_sel, cfg.temp_sensor_sel, cfg.burnout_source_en};

   acc_host_model acc_host_model_inst (.core_clk(core_clk), .rst(rst), .go(go), .wr(wr), .addr(addr),
      .wdata(wdata), .bad(bad), .reg_strobe(reg_strobe), .reg_req(reg_req));

   // event bits: start, sleep, conv start, conv done, ready, read done
   acc_config_regs #(.EXT_CLK_HZ(EXT_HZ)) acc_config_regs_inst (.core_clk(core_clk), .rst(rst),
      .reg_strobe(reg_strobe), .reg_req(reg_req), .reg_rdata(rdata), .reg_hit(hit), .start_cmd(ev[5]),
      .sleep_cmd(ev[4]), .conv_start(ev[3]), .conv_done(ev[2]), .data_ready_event(ev[1]),
      .data_read_done(ev[0]), .active_cfg(cfg), .ignore_reg_zero(ign), .internal_ref_forced(iref),
      .rate_csps(rate), .rate_valid(rv), .line_reject_misuse(misuse), .lowside_switch_closed(sw),
      .source_one_ain_en(a1), .source_two_ain_en(a2), .source_one_ref_en(r1), .source_two_ref_en(r2),
      .excitation_magnitude_sel(mag), .data_ready_n(rdy_n), .shared_out_ready_req(shr));

   // expected rate in centi-samples, scaled by the chosen clock
   function automatic logic [31:0] rate_of(input logic [1:0] m, input logic [2:0] c);
      int t [3][7] = '{'{2000, 4500, 9000, 17500, 33000, 60000, 100000},
         '{500, 1125, 2250, 4400, 8250, 15000, 25000}, '{4000, 9000, 18000, 35000, 66000, 120000, 200000}};
      return 32'(longint'(t[m][c]) * EXT_HZ / ACC_NOM_CLK_HZ);
   endfunction

   // what the bank should hold after the host scrubs a write
   function automatic logic [7:0] exp_val(input logic [1:0] a, input logic [7:0] d);
      logic [7:0] v = d;
      if (!bad && a == ACC_OFF_REF_FILT && !(exp_r[1][7:5] == 3'h0 && !exp_r[1][4])) v[5:4] = 2'h0;
      if (!bad && a == ACC_OFF_ROUTE_RDY) v[0] = 1'b0;
      return v;
   endfunction

   function automatic logic [3:0] ain(input logic [2:0] s);
      return (s >= 3'h1 && s <= 3'h4) ? 4'h1 << (s - 3'h1) : 4'h0;
   endfunction

   function automatic logic [1:0] rf(input logic [2:0] s);
      return s == 3'h5 ? 2'h1 : s == 3'h6 ? 2'h2 : 2'h0;
   endfunction

   task automatic report(input logic ok, input string what);
      n_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
      report(got === exp, what);
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      report(got === exp, what);
   endtask

   task automatic chk_rate(input logic [31:0] got, input logic [31:0] exp, input string what);
      report(got === exp, what);
   endtask

   // strobe stays up after the taking edge so writes can run back to back
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(negedge core_clk);
      go = 1;
      wr = 1;
      addr = a;
      wdata = d;
      if (a != 2'h0) exp_r[a] = exp_val(a, d);
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [1:0] a);
      @(negedge core_clk);
      go = 1;
      wr = 0;
      addr = a;
      #5;
      chk_reg(rdata, exp_r[a], "readback");
      chk_bit(hit, a != 2'h0, "address decode");
   endtask

   task automatic idle();
      @(negedge core_clk);
      go = 0;
      @(negedge core_clk);
   endtask

   task automatic pulse(input logic [5:0] m);
      @(negedge core_clk);
      ev = m;
      @(negedge core_clk);
      ev = 6'h00;
      #5;
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog, about twenty times the expected run
   initial begin
      #400000;
      miscompares++;
      conclude();
   end

   // main sequence
   initial begin
      exp_r = '{default: 8'h00};
      repeat (12) @(negedge core_clk);
      rst = 0;
      for (int a = 0; a < 4; a++) rd(2'(a));
      chk_bit(rdy_n, 1'b1, "ready idle");
      chk_bit(sw, 1'b0, "switch open");
      chk_rate(rate, rate_of(2'h0, 3'h0), "reset rate");
      chk_reg({5'h0, ctb}, 8'h0, "cfg");
      $display("test reset done");
      for (int i = 0; i < 60; i++) begin
         wr_reg(2'($unsigned($random(seed)) % 4), 8'($random(seed)));
         rd(2'($unsigned($random(seed)) % 4));
      end
      $display("test random traffic done");
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 8; c++) begin
            wr_reg(ACC_OFF_RATE_MODE, {3'(c), 2'(m), 3'h0});
            idle();
            chk_bit(rv, m != 3 && c != 7, "rate valid");
            if (m != 3 && c != 7) chk_rate(rate, rate_of(2'(m), 3'(c)), "rate");
            chk_reg({cfg.rate_code, 2'(cfg.mode), 3'h0}, {3'(c), 2'(m), 3'h0}, "rate fields");
         end
      end
      // external reference, so the forced flag can only come from the temp bit
      wr_reg(ACC_OFF_REF_FILT, 8'h40);
      for (int b = 0; b < 8; b++) begin
         wr_reg(ACC_OFF_RATE_MODE, 8'(b));
         idle();
         chk_reg({5'h0, ctb}, 8'(b), "bits");
         chk_reg({6'h0, ign, iref}, {6'h0, b[1], b[1]}, "temp sensor");
      end
      wr_reg(ACC_OFF_RATE_MODE, 8'h00);
      $display("test rate and mode done");
      for (int i = 0; i < 32; i++) begin
         wr_reg(ACC_OFF_REF_FILT, {2'(i >> 3), 3'h0, 3'(i)});
         idle();
         em = (3'(i) == ACC_MAG_RSVD) ? 3'h0 : 3'(i);
         chk_reg({2'(cfg.vref_sel), 3'h0, mag}, {2'(i >> 3), 3'h0, em}, "ref");
      end
      for (int j = 0; j < 4; j++) begin
         wr_reg(ACC_OFF_REF_FILT, 8'(j << 4));
         idle();
         chk_reg({6'h0, cfg.line_reject}, 8'(j), "line reject");
         chk_bit(misuse, 1'b0, "no misuse");
      end
      wr_reg(ACC_OFF_RATE_MODE, 8'h20);
      idle();
      bad = 1;
      wr_reg(ACC_OFF_REF_FILT, 8'h10);
      idle();
      chk_bit(misuse, 1'b1, "misuse flagged");
      bad = 0;
      wr_reg(ACC_OFF_REF_FILT, 8'h10);
      idle();
      rd(ACC_OFF_REF_FILT);
      chk_bit(misuse, 1'b0, "scrubbed");
      $display("test reference and filter done");
      for (int s = 0; s < 8; s++) begin
         wr_reg(ACC_OFF_ROUTE_RDY, {3'(s), 3'(7 - s), 2'h1});
         idle();
         rd(ACC_OFF_ROUTE_RDY);
         chk_reg({a1, a2}, {ain(3'(s)), ain(3'(7 - s))}, "input routing");
         chk_reg({4'h0, r1, r2}, {4'h0, rf(3'(s)), rf(3'(7 - s))}, "ref routing");
      end
      for (int k = 0; k < 2; k++) begin
         wr_reg(ACC_OFF_ROUTE_RDY, {6'h0, 1'(k), 1'b0});
         idle();
         pulse(6'h02);
         chk_reg({6'h0, rdy_n, shr}, {6'h0, 1'b0, 1'(k)}, "ready raised");
         pulse(6'h01);
         chk_reg({6'h0, rdy_n, shr}, 8'h02, "ready cleared");
      end
      $display("test routing and ready done");
      wr_reg(ACC_OFF_REF_FILT, 8'h00);
      idle();
      pulse(6'h20);
      chk_bit(sw, 1'b0, "switch stays open");
      wr_reg(ACC_OFF_REF_FILT, 8'h08);
      idle();
      pulse(6'h20);
      chk_bit(sw, 1'b1, "switch closed");
      pulse(6'h10);
      chk_bit(sw, 1'b0, "switch opened by sleep");
      for (int a = 1; a < 4; a++) rd(2'(a));
      pulse(6'h20);
      wr_reg(ACC_OFF_REF_FILT, 8'h00);
      idle();
      chk_bit(sw, 1'b0, "switch opened by clear");
      $display("test switch done");
      wr_reg(ACC_OFF_RATE_MODE, 8'h00);
      idle();
      pulse(6'h08);
      wr_reg(ACC_OFF_RATE_MODE, 8'h60);
      idle();
      chk_reg({5'h0, cfg.rate_code}, 8'h00, "frozen in conversion");
      rd(ACC_OFF_RATE_MODE);
      pulse(6'h04);
      idle();
      chk_reg({5'h0, cfg.rate_code}, 8'h03, "applied after");
      $display("test conversion latch done");
      conclude();
   end
endmodule
